// ===== core/swdt_top.sv
// Notes on behaviour
// - Counter clocked by oscillator divided 4096/1024/128
// - Eight-bit tick counter, readable, never writable
// - Reset clears control: watchdog on, divide 4096
// - Only 1010 in top nibble disarms watchdog
// - Writing one to bit 1 clears counter, in run state only
// - Writing one to bit 0 clears divider
// - Armed watchdog resets system on every overflow
// - Overflow is carry out of counter bit 7
// - Wake from stop restarts oscillator and counting
// - After reset divide 4096; after wake keep selection
// - Counter bit 7 ends stabilization, CPU clock resumes
`timescale 1ns/1ps
module swdt_top
    import swdt_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic [REG_AW-1:0] reg_addr,
    input  wire logic [REG_DW-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [REG_DW-1:0] reg_rdata,
    input  wire logic              stop_req,
    input  wire logic              ext_wake,
    output logic                   osc_enable,
    output logic                   cpu_clk_enable,
    output logic                   stab_done,
    output logic                   sys_reset_req,
    output logic                   wdt_enabled,
    output logic                   irq
);
    import swdt_pkg::*;

    // Operating states of the core:
    //   run  - oscillator on, CPU clocked, counter watched
    //   stop - oscillator off, counter and divider frozen
    //   stab - oscillator on, CPU clock held until bit 7
    // Reset and a watchdog fire both land in stab at divide
    // 4096, so a runaway program gets no clock before the
    // oscillator has settled again.
    // Software sees control and the read-only counter, plus
    // a status and a mask register for the two events.

    // Address match, shared by every strobe decoder
    function automatic logic reg_hit(
        input logic [REG_AW-1:0] addr,
        input logic [REG_AW-1:0] ofs
    );
        return addr == ofs;
    endfunction : reg_hit

    // Whole state of the core
    // Packed, so one register statement covers all of it
    typedef struct packed {
        swdt_state_t      state;      // Run, stop or stabilizing
        logic [7:0]       ctl;        // Timer control, clear bits dropped
        logic [CNT_W-1:0] cnt;        // Tick counter
        logic [7:0]       rdata;      // Read data, one cycle after strobe
        logic             wake_s1;    // Wake pin, first stage
        logic             wake_s2;    // Wake pin, second stage
        logic             rst_req;    // Watchdog reset pulse
        logic             stab_pulse; // Stabilization done pulse
    } swdt_core_t;

    swdt_core_t q;          // Registered state
    swdt_core_t n;          // Next state

    // Decoded bus strobes
    logic wr_ctl;           // Write to timer control
    logic wr_status;        // Write to interrupt status
    logic wr_mask;          // Write to interrupt mask

    // Divider interface
    logic      tick;        // One counter step
    logic      div_clr;     // Divider clear
    logic      div_run;     // Divider running
    swdt_sel_t div_sel;     // Ratio select

    // Events of this cycle
    logic cnt_clr;          // Software counter clear
    logic ovf;              // Counter carry out
    logic wdt_fire;         // Overflow while armed
    logic stab_end;         // Stabilization interval elapsed

    // Interrupt unit link
    // Events and bus strobes travel to the unit together
    swdt_irq_if irq_bus ();

    // Address decode for writes; strobes last one cycle,
    // so every write acts exactly once.
    // The tick counter has no write decode: it is read-only.
    always_comb
    begin
        wr_ctl    = reg_wr && reg_hit(reg_addr, OFS_TIMER_CONTROL);
        wr_status = reg_wr && reg_hit(reg_addr, OFS_IRQ_STATUS);
        wr_mask   = reg_wr && reg_hit(reg_addr, OFS_IRQ_MASK);
    end

    // Counter clear request from software
    assign cnt_clr = wr_ctl && reg_wdata[CTL_CNT_CLR];

    // Carry out of bit 7 is the only overflow
    // Disarmed, the counter wraps to zero; the carry is still an event
    assign ovf = (q.state == ST_RUN) && tick && (q.cnt == CNT_MAX) && !cnt_clr;

    // A clear in the overflow cycle counts as serviced in time
    // Kept combinational so the divider clear lands on the same edge
    assign wdt_fire = ovf && swdt_wdt_on(q.ctl);

    // Bit 7 set while stabilizing ends the interval
    // Bit 7 stays set until the counter restarts, so a level test is safe
    assign stab_end = (q.state == ST_STAB) && q.cnt[STAB_BIT];

    // Divider only runs while the oscillator does
    // Freezing rather than clearing keeps its phase across a stop
    assign div_run = (q.state != ST_STOP);

    // Divider clears on software request and on watchdog reset
    // The clear bit is never stored, so it acts once per write
    assign div_clr = (wr_ctl && reg_wdata[CTL_DIV_CLR]) || wdt_fire;

    // Ratio comes from the stored select field
    // Codes 10 and 11 both give divide 128
    assign div_sel = swdt_sel_t'(q.ctl[CTL_SEL_LSB +: 2]);

    // Oscillator divider
    // Tick is a one-cycle strobe of this clock domain
    swdt_prescaler #(
        .WIDTH (DIV_W)
    ) u_prescaler (
        .clk    (clk),
        .resetn (resetn),
        .run    (div_run),
        .clr    (div_clr),
        .sel    (div_sel),
        .tick   (tick)
    );

    // Interrupt unit hookup
    // Overflow is reported even when disarmed, so software
    // can still see that a service was missed
    always_comb
    begin
        irq_bus.evt            = '0;
        irq_bus.evt[IRQ_OVF]   = ovf;
        irq_bus.evt[IRQ_STAB]  = stab_end;
        irq_bus.wdata          = reg_wdata[IRQ_W-1:0];
        irq_bus.status_wr      = wr_status;
        irq_bus.mask_wr        = wr_mask;
    end

    // Sticky status and mask
    // Not cleared by a watchdog fire, so the cause stays visible
    swdt_irq u_irq (
        .clk    (clk),
        .resetn (resetn),
        .bus    (irq_bus)
    );

    // Next-state logic for the whole core
    // Default: hold everything; pulses drop after one cycle
    always_comb
    begin
        n            = q;
        n.rst_req    = 1'b0;
        n.stab_pulse = 1'b0;

        // Wake pin crosses in through two stages
        // Only the second stage is read by the state logic
        n.wake_s1 = ext_wake;
        n.wake_s2 = q.wake_s1;

        // Clear bits act once and are not kept
        // Stored, they would read back as ones forever
        if (wr_ctl)
            n.ctl = reg_wdata & CTL_KEEP;

        // Only run honours a stop request; elsewhere it is dropped
        case (q.state)
            ST_RUN:
            begin
                // Normal counting; software clear beats a step
                if (cnt_clr)
                    n.cnt = RST_TICK_COUNTER;
                else if (tick)
                    n.cnt = q.cnt + CNT_W'(1);
                // Armed overflow restarts this block like a reset
                // A fire outranks a stop in the same cycle, so the
                // reset is never lost behind a halted oscillator
                if (wdt_fire)
                begin
                    n.rst_req = 1'b1;
                    n.ctl     = RST_TIMER_CONTROL;
                    n.cnt     = RST_TICK_COUNTER;
                    n.state   = ST_STAB;
                end
                else if (stop_req)
                begin
                    // Oscillator halts; counter and divider freeze
                    n.state = ST_STOP;
                end
            end

            ST_STOP:
            begin
                // Wake keeps the chosen ratio, counts from zero
                // Divider keeps its phase; only the counter restarts
                // A reset in stop goes through the asynchronous branch
                if (q.wake_s2)
                begin
                    n.state = ST_STAB;
                    n.cnt   = RST_TICK_COUNTER;
                end
            end

            ST_STAB:
            begin
                // CPU clock held off until bit 7 sets
                // The counter clear is not honoured here: the interval
                // runs to its end; ratio, signature and divider clear still act
                if (stab_end)
                begin
                    n.state      = ST_RUN;
                    n.stab_pulse = 1'b1;
                end
                else if (tick)
                    n.cnt = q.cnt + CNT_W'(1);
            end

            default:
            begin
                // Unused code falls back to a safe restart
                // Code 11 is the only one that can land here
                n.state = ST_STAB;
                n.cnt   = RST_TICK_COUNTER;
            end
        endcase

        // Read data valid only in the cycle after the strobe
        // Zero when idle, so read buses can be OR-ed together
        // Unmapped offsets and the clear bits read as zero
        n.rdata = '0;
        if (reg_rd)
        begin
            case (reg_addr)
                OFS_TIMER_CONTROL: n.rdata = q.ctl;
                OFS_TICK_COUNTER:  n.rdata = q.cnt;
                OFS_IRQ_STATUS:    n.rdata = {{(8-IRQ_W){1'b0}}, irq_bus.status};
                OFS_IRQ_MASK:      n.rdata = {{(8-IRQ_W){1'b0}}, irq_bus.mask};
                default:           n.rdata = '0;
            endcase
        end
    end

    // State register; reset starts stabilization at divide 4096
    // Constants only in the reset branch; the divider resets
    // in its own module, so both restart in step
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            q.state      <= ST_STAB;
            q.ctl        <= RST_TIMER_CONTROL;
            q.cnt        <= RST_TICK_COUNTER;
            q.rdata      <= '0;
            q.wake_s1    <= 1'b0;
            q.wake_s2    <= 1'b0;
            q.rst_req    <= 1'b0;
            q.stab_pulse <= 1'b0;
        end
        else
            q <= n;
    end

    // Outputs; the system reset pulse is one cycle, the
    // reset controller outside must stretch it if needed
    // Read data straight from its register
    assign reg_rdata      = q.rdata;
    // Oscillator runs in every state but stop
    assign osc_enable     = (q.state != ST_STOP);
    // CPU clock only once the oscillator has settled
    assign cpu_clk_enable = (q.state == ST_RUN);
    // One-cycle pulse at the end of stabilization
    assign stab_done      = q.stab_pulse;
    // One-cycle reset request on an armed overflow
    assign sys_reset_req  = q.rst_req;
    // Arm state decoded from the stored signature
    assign wdt_enabled    = swdt_wdt_on(q.ctl);
    // Level interrupt from the sticky unit
    assign irq            = irq_bus.irq;

endmodule : swdt_top

// ===== core/swdt_pkg.sv
package swdt_pkg;

    // Register port widths
    localparam int unsigned REG_AW = 8;
    localparam int unsigned REG_DW = 8;

    // Register offsets
    localparam logic [7:0] OFS_TIMER_CONTROL = 8'hD3;
    localparam logic [7:0] OFS_TICK_COUNTER  = 8'hFD;
    localparam logic [7:0] OFS_IRQ_STATUS    = 8'hF9;
    localparam logic [7:0] OFS_IRQ_MASK      = 8'hFA;

    // Reset values
    localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;
    localparam logic [7:0] RST_TICK_COUNTER  = 8'h00;
    localparam logic [1:0] RST_IRQ           = 2'h0;

    // Control field positions
    localparam int unsigned CTL_SIG_LSB = 4;
    localparam int unsigned CTL_SEL_LSB = 2;
    localparam int unsigned CTL_CNT_CLR = 1;
    localparam int unsigned CTL_DIV_CLR = 0;
    localparam logic [7:0]  CTL_KEEP    = 8'hFC;  // Clear bits never stored
    localparam logic [3:0]  SIG_WDT_OFF = 4'hA;   // Only pattern that disarms

    // Divider and counter
    localparam int unsigned DIV_W    = 12;
    localparam logic [11:0] TOP_4096 = 12'hFFF;
    localparam logic [11:0] TOP_1024 = 12'h3FF;
    localparam logic [11:0] TOP_128  = 12'h07F;
    localparam int unsigned CNT_W    = 8;
    localparam int unsigned STAB_BIT = 7;
    localparam logic [7:0]  CNT_MAX  = 8'hFF;

    // Interrupt status bits
    localparam int unsigned IRQ_W    = 2;
    localparam int unsigned IRQ_OVF  = 0;
    localparam int unsigned IRQ_STAB = 1;

    // Divider selection
    typedef enum logic [1:0] {
        SEL_4096  = 2'b00,
        SEL_1024  = 2'b01,
        SEL_128   = 2'b10,
        SEL_128_B = 2'b11
    } swdt_sel_t;

    // Block operating states
    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,
        ST_STOP = 2'b01,
        ST_STAB = 2'b10
    } swdt_state_t;

    // Watchdog armed unless the signature sits in the top nibble
    function automatic logic swdt_wdt_on(input logic [7:0] ctl);
        return ctl[CTL_SIG_LSB +: 4] != SIG_WDT_OFF;
    endfunction : swdt_wdt_on

endpackage : swdt_pkg

// ===== core/swdt_irq_if.sv
`timescale 1ns/1ps
interface swdt_irq_if;
    import swdt_pkg::*;
    logic [IRQ_W-1:0] evt;        // One-cycle event pulses
    logic [IRQ_W-1:0] wdata;      // Bus write data, low bits
    logic             status_wr;  // Write-one-to-clear strobe
    logic             mask_wr;    // Mask write strobe
    logic [IRQ_W-1:0] status;     // Sticky status
    logic [IRQ_W-1:0] mask;       // Mask bits
    logic             irq;        // Level interrupt

    modport ctrl (output evt, wdata, status_wr, mask_wr, input status, mask, irq);
    modport unit (input evt, wdata, status_wr, mask_wr, output status, mask, irq);
endinterface : swdt_irq_if

// ===== core/swdt_prescaler.sv
`timescale 1ns/1ps
module swdt_prescaler
    import swdt_pkg::*;
#(
    parameter int unsigned WIDTH = DIV_W
)
(
    input  wire logic      clk,
    input  wire logic      resetn,
    input  wire logic      run,     // Oscillator running
    input  wire logic      clr,     // Divider clear
    input  wire swdt_sel_t sel,     // Ratio select
    output logic           tick     // One pulse per divided period
);
    import swdt_pkg::*;

    // Whole state of the divider
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
    } swdt_div_t;

    swdt_div_t        q;
    swdt_div_t        n;
    logic [WIDTH-1:0] top;

    // Ratio decode
    always_comb
    begin
        case (sel)
            SEL_4096: top = WIDTH'(TOP_4096);
            SEL_1024: top = WIDTH'(TOP_1024);
            default:  top = WIDTH'(TOP_128);
        endcase
    end

    // Tick not gated by clr, so a clear it triggers cannot loop back
    assign tick = run && ((q.cnt & top) == top);

    // Next divider value; clear wins over counting
    always_comb
    begin
        n = q;
        if (clr)
            n.cnt = '0;
        else if (run)
            n.cnt = q.cnt + WIDTH'(1);
    end

    // State register
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            q <= '0;
        else
            q <= n;
    end

endmodule : swdt_prescaler

// ===== core/swdt_irq.sv
`timescale 1ns/1ps
module swdt_irq
    import swdt_pkg::*;
(
    input  wire logic clk,
    input  wire logic resetn,
    swdt_irq_if.unit  bus      // Events in, status out
);
    import swdt_pkg::*;

    // Whole state of the interrupt unit
    typedef struct packed {
        logic [IRQ_W-1:0] status;
        logic [IRQ_W-1:0] mask;
    } swdt_irq_t;

    swdt_irq_t q;
    swdt_irq_t n;

    // Per-bit sticky status; a new event beats a same-cycle clear
    always_comb
    begin
        n = q;
        for (int i = 0; i < IRQ_W; i++)
        begin
            if (bus.status_wr && bus.wdata[i])
                n.status[i] = 1'b0;
            if (bus.evt[i])
                n.status[i] = 1'b1;
        end
        if (bus.mask_wr)
            n.mask = bus.wdata;
    end

    // State register
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            q.status <= RST_IRQ;
            q.mask   <= RST_IRQ;
        end
        else
            q <= n;
    end

    assign bus.status = q.status;
    assign bus.mask   = q.mask;
    assign bus.irq    = |(q.status & q.mask);

endmodule : swdt_irq

// ===== sim/swdt_props.sv
`timescale 1ns/1ps
module swdt_props
    import swdt_pkg::*;
(
    input wire logic              clk,
    input wire logic              resetn,
    input wire logic [REG_AW-1:0] reg_addr,
    input wire logic [REG_DW-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [REG_DW-1:0] reg_rdata,
    input wire logic              stop_req,
    input wire logic              ext_wake,
    input wire logic              osc_enable,
    input wire logic              cpu_clk_enable,
    input wire logic              stab_done,
    input wire logic              sys_reset_req,
    input wire logic              wdt_enabled,
    input wire logic              irq
);
    // Signature nibble of a control write
    wire logic [3:0] sig_nib = reg_wdata[7:4];
    wire logic       ctl_wr  = reg_wr && reg_addr == OFS_TIMER_CONTROL;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Read data only in the cycle after a strobe
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    // A fire in the same cycle overrides the write
    a_wdt_signature: assert property ($past(ctl_wr) && !sys_reset_req
        |-> wdt_enabled == ($past(sig_nib) != 4'hA))
        else $error("watchdog arm state wrong after write");
    a_reset_clears: assert property (sys_reset_req |-> wdt_enabled && !cpu_clk_enable)
        else $error("watchdog reset left block running");
    a_reset_pulse: assert property (sys_reset_req |=> !sys_reset_req)
        else $error("reset request longer than one cycle");
    a_reset_armed: assert property (sys_reset_req |-> $past(wdt_enabled))
        else $error("reset request while disarmed");
    a_stab_end: assert property (stab_done |-> cpu_clk_enable && !$past(cpu_clk_enable))
        else $error("stabilization end without cpu clock");
    a_stop_osc: assert property (stop_req && cpu_clk_enable |=> !osc_enable)
        else $error("oscillator kept running in stop");
    a_wake_osc: assert property (!osc_enable && ext_wake |-> ##[1:4] osc_enable)
        else $error("oscillator not restarted on wake");
    a_osc_run: assert property (cpu_clk_enable |-> osc_enable)
        else $error("cpu clock without oscillator");

    // Main scenarios reached
    c_fire: cover property (sys_reset_req);
    c_stab: cover property (stab_done);
    c_stop: cover property (!osc_enable);
    c_wake: cover property ($rose(osc_enable));
endmodule : swdt_props

bind swdt_top swdt_props i_swdt_props (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .stop_req(stop_req), .ext_wake(ext_wake), .osc_enable(osc_enable),
    .cpu_clk_enable(cpu_clk_enable), .stab_done(stab_done), .sys_reset_req(sys_reset_req),
    .wdt_enabled(wdt_enabled), .irq(irq));

// ===== sim/swdt_top_bench.sv
`timescale 1ns/1ps
module swdt_top_bench;
    import swdt_pkg::*;
    logic       clk       = 1'b0;  // Bench clock
    logic       resetn    = 1'b0;  // Held low first
    logic [7:0] reg_addr  = 8'h00; // Bus address
    logic [7:0] reg_wdata = 8'h00; // Bus write data
    logic       reg_wr    = 1'b0;  // Write strobe
    logic       reg_rd    = 1'b0;  // Read strobe
    logic       stop_req  = 1'b0;  // Stop entry
    logic       ext_wake  = 1'b0;  // Wake pin
    logic [7:0] reg_rdata;
    logic       osc_enable;
    logic       cpu_clk_enable;
    logic       stab_done;
    logic       sys_reset_req;
    logic       wdt_enabled;
    logic       irq;
    int         error_cnt = 0;     // Mismatches
    int         checked   = 0;     // Comparisons
    logic [7:0] v;                 // Last read
    int         n;                 // Cycles waited

    // Clock, 8 ns period
    always #4 clk = ~clk;

    swdt_top i_swdt_top (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stop_req(stop_req),
        .ext_wake(ext_wake), .osc_enable(osc_enable), .cpu_clk_enable(cpu_clk_enable),
        .stab_done(stab_done), .sys_reset_req(sys_reset_req), .wdt_enabled(wdt_enabled), .irq(irq));

    // One-cycle write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // One-cycle read, data taken in the following cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("FAIL %0t byte %h expected %h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("FAIL %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    // Bounded wait for a pulse: 0 stabilization end, 1 reset request
    task automatic wait_ev(input bit which, input int lim, output int cnt);
        cnt = 0;
        do
        begin
            @(posedge clk);
            #1 cnt++;
        end while (cnt < lim && (which ? sys_reset_req : stab_done) !== 1'b1);
    endtask : wait_ev

    // Reset values, unmapped read, slowest rate after reset
    task automatic t_reset();
        rd(OFS_TIMER_CONTROL, v);
        chk_byte(v, 8'h00);
        chk_bit(wdt_enabled, 1'b1);
        chk_bit(cpu_clk_enable, 1'b0);
        rd(8'h10, v);
        chk_byte(v, 8'h00);
        repeat (4096 + 16) @(posedge clk);
        rd(OFS_TICK_COUNTER, v);
        chk_byte(v, 8'h01);
    endtask : t_reset

    // Speed up stabilization, then bit 7 ends it
    task automatic t_stab();
        wr(OFS_TIMER_CONTROL, 8'h0B);
        wait_ev(0, 16700, n);
        chk_bit(n < 16700, 1'b1);
        chk_bit(cpu_clk_enable, 1'b1);
        rd(OFS_TICK_COUNTER, v);
        chk_byte(v, 8'h80);
        rd(OFS_IRQ_STATUS, v);
        chk_byte(v, 8'h02);
        wr(OFS_IRQ_STATUS, 8'h03);
        rd(OFS_IRQ_STATUS, v);
        chk_byte(v, 8'h00);
    endtask : t_stab

    // Counter cannot be written, clear bit zeroes it
    task automatic t_ro();
        wr(OFS_TIMER_CONTROL, 8'h0B);
        wr(OFS_TICK_COUNTER, 8'h55);
        rd(OFS_TICK_COUNTER, v);
        chk_byte(v, 8'h00);
    endtask : t_ro

    // Faster ratios, both codes of 128: one step after one divided period
    task automatic t_rates();
        int div;
        for (int s = 1; s <= 3; s++)
        begin
            div = (s == 1) ? 1024 : 128;
            wr(OFS_TIMER_CONTROL, {4'h0, s[1:0], 2'b11});
            repeat (div + 10) @(posedge clk);
            rd(OFS_TICK_COUNTER, v);
            chk_byte(v, 8'h01);
        end
    endtask : t_rates

    // Armed overflow after exactly 256 steps of 128
    task automatic t_wdog();
        wr(OFS_TIMER_CONTROL, 8'h0B);
        wait_ev(1, 33100, n);
        chk_bit(n > 32740 && n < 32800, 1'b1);
        rd(OFS_TIMER_CONTROL, v);
        chk_byte(v, 8'h00);
        chk_bit(wdt_enabled, 1'b1);
    endtask : t_wdog

    // Signature disarms: overflow only raises the interrupt
    task automatic t_disarm();
        wr(OFS_TIMER_CONTROL, 8'hAB);
        #1 chk_bit(wdt_enabled, 1'b0);
        wr(OFS_IRQ_MASK, 8'h01);
        wait_ev(1, 33100, n);
        chk_bit(sys_reset_req, 1'b0);
        chk_bit(irq, 1'b1);
        rd(OFS_IRQ_STATUS, v);
        chk_byte(v, 8'h03);
        // Wrapped to zero at the carry, two steps of 128 ago
        rd(OFS_TICK_COUNTER, v);
        chk_byte(v, 8'h02);
        wr(OFS_IRQ_STATUS, 8'h03);
        #1 chk_bit(irq, 1'b0);
        wr(OFS_IRQ_MASK, 8'h00);
        wr(OFS_TIMER_CONTROL, 8'h5B);
        #1 chk_bit(wdt_enabled, 1'b1);
    endtask : t_disarm

    // Stop, wake, stabilization at the kept ratio
    task automatic t_wake();
        @(posedge clk);
        stop_req <= 1'b1;
        @(posedge clk);
        stop_req <= 1'b0;
        #1 chk_bit(osc_enable, 1'b0);
        repeat (20) @(posedge clk);
        ext_wake <= 1'b1;
        repeat (4) @(posedge clk);
        #1 chk_bit(osc_enable, 1'b1);
        @(posedge clk);
        ext_wake <= 1'b0;
        wait_ev(0, 16700, n);
        chk_bit(n < 16700, 1'b1);
        chk_bit(cpu_clk_enable, 1'b1);
    endtask : t_wake

    // Verdict and end of run
    task automatic summarize();
        if (error_cnt == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_stab();
        t_ro();
        t_rates();
        t_wdog();
        t_disarm();
        t_wake();
        summarize();
    end

    // Hang guard, well past the expected run
    initial
    begin
        #1100000;
        error_cnt++;
        $display("FAIL %0t run did not finish", $time);
        summarize();
    end
endmodule : swdt_top_bench
